// ### rtl/itx_pkg.sv
// Purpose: Shared constants and types of the interrupt/timer instruction executor
// Assumes: 4-bit core datapath, one system clock
// Notes: Operation codes are local to this block, not the core's opcode map
package itx_pkg;
  localparam int NIB_W = 4;
  localparam int CNT_W = 8;
  localparam int NUM_FLAGS = 3;
  // Flag slots in the request flag bank
  localparam int FLG_EXT0 = 0;
  localparam int FLG_T1 = 1;
  localparam int FLG_T2 = 2;
  // Bit positions inside the control nibbles
  localparam int EXT0_EN_BIT = 0;
  localparam int T1_EN_BIT = 2;
  localparam int T2_EN_BIT = 3;
  localparam int PIN_LVL_BIT = 2;
  // Reset values
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [7:0] RST_CNT = 8'h00;
  localparam logic RST_GIE = 1'b0;
  localparam logic RST_PIN = 1'b1;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_IRQ_OFF = 5'h01,
    OP_IRQ_ON = 5'h02,
    OP_SKIP_EXT0 = 5'h03,
    OP_SKIP_PIN = 5'h04,
    OP_SKIP_T1 = 5'h05,
    OP_SKIP_T2 = 5'h06,
    OP_RD_ICTL1 = 5'h07,
    OP_WR_ICTL1 = 5'h08,
    OP_RD_ICTL2 = 5'h09,
    OP_WR_ICTL2 = 5'h0a,
    OP_RD_ICTL3 = 5'h0b,
    OP_WR_ICTL3 = 5'h0c,
    OP_RD_TCTL1 = 5'h0d,
    OP_WR_TCTL1 = 5'h0e,
    OP_RD_TCTL2 = 5'h0f,
    OP_WR_TCTL2 = 5'h10,
    OP_RD_TCTL3 = 5'h11,
    OP_WR_TCTL3 = 5'h12,
    OP_RD_TMR1 = 5'h13,
    OP_WR_TMR1 = 5'h14,
    OP_RD_TMR2 = 5'h15,
    OP_WR_TMR2 = 5'h16,
    OP_WR_RLD1 = 5'h17
  } itx_op_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_SKIP = 2'b10
  } itx_state_t;
endpackage

// ### rtl/itx_flag_if.sv
// Purpose: Carrier between executor and request flag bank
// Assumes: Same clock on both sides
// Notes: Set and clear are one-cycle pulses
`timescale 1ns/1ps
interface itx_flag_if;
  logic [itx_pkg::NUM_FLAGS-1:0] set;
  logic [itx_pkg::NUM_FLAGS-1:0] clr;
  logic [itx_pkg::NUM_FLAGS-1:0] flag;
  modport ctl (output set, output clr, input flag);
  modport bank (input set, input clr, output flag);
endinterface

// ### rtl/itx_flags.sv
// Purpose: Sticky interrupt request flags
// Assumes: Set and clear pulses from logic on ref_clk
// Notes: A set in the cycle of a clear keeps the flag
`timescale 1ns/1ps
module itx_flags
(
  input wire logic ref_clk,
  input wire logic arst_n,
  itx_flag_if.bank fl
);
  typedef struct packed {
    logic [itx_pkg::NUM_FLAGS-1:0] flag;
  } itx_fst_t;

  itx_fst_t q;
  itx_fst_t d;
  logic [itx_pkg::NUM_FLAGS-1:0] nxt;

  genvar i;
  generate
    for (i = 0; i < itx_pkg::NUM_FLAGS; i++)
    begin : g_flag
      // Set wins so no request is lost
      assign nxt[i] = fl.set[i] | (q.flag[i] & ~fl.clr[i]);
    end
  endgenerate

  always_comb
  begin
    d = q;
    d.flag = nxt;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign fl.flag = q.flag;

  set_wins_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fl.set[0] |=> fl.flag[0]) else $error("Request set lost");
endmodule

// ### rtl/itx_exec.sv
// Purpose: Executes interrupt and timer transfer instructions of the core
// Assumes: Sequencer gives one decoded operation per instr_valid pulse
// Notes: Timer counting lives outside; this block only loads and reads it
`timescale 1ns/1ps
module itx_exec
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire itx_pkg::itx_op_t instr_op,
  input wire logic [3:0] acc_in,
  input wire logic [3:0] b_in,
  input wire logic ext_int_pin,
  input wire logic ext0_req_set,
  input wire logic first_timer_req_set,
  input wire logic second_timer_req_set,
  input wire logic [7:0] first_timer_count,
  input wire logic [7:0] second_timer_count,
  output logic skip_next,
  output logic [3:0] acc_out,
  output logic acc_we,
  output logic [3:0] b_out,
  output logic b_we,
  output logic irq_global_enable,
  output logic [3:0] irq_ctrl_first,
  output logic [3:0] irq_ctrl_second,
  output logic [3:0] irq_ctrl_third,
  output logic [3:0] tmr_ctrl_first,
  output logic [3:0] tmr_ctrl_second,
  output logic [3:0] tmr_ctrl_third,
  output logic first_timer_load,
  output logic second_timer_load,
  output logic [7:0] timer_load_value,
  output logic [7:0] first_timer_reload,
  output logic [7:0] second_timer_reload,
  output logic ext0_req_flag,
  output logic first_timer_req_flag,
  output logic second_timer_req_flag
);
  typedef struct packed {
    itx_pkg::itx_state_t st;
    logic gie;
    logic [3:0] ic1;
    logic [3:0] ic2;
    logic [3:0] ic3;
    logic [3:0] tc1;
    logic [3:0] tc2;
    logic [3:0] tc3;
    logic [7:0] rl1;
    logic [7:0] rl2;
    logic [3:0] acc;
    logic acc_we;
    logic [3:0] b;
    logic b_we;
    logic t1_ld;
    logic t2_ld;
    logic [7:0] ld_val;
    logic [2:0] pin_sync;
    logic pin_lvl;
  } itx_est_t;

  itx_est_t q;
  itx_est_t d;
  logic exec;
  logic [2:0] clr;
  logic [2:0] flags;

  itx_flag_if fl ();

  itx_flags u_flags
  (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .fl(fl.bank)
  );

  assign fl.set = {second_timer_req_set, first_timer_req_set, ext0_req_set};
  assign fl.clr = clr;
  assign flags = fl.flag;

  // Instruction acts only in run state; in skip state it is swallowed
  assign exec = instr_valid && (q.st == itx_pkg::ST_RUN);

  always_comb
  begin
    d = q;
    clr = 3'h0;
    d.acc_we = 1'b0;
    d.b_we = 1'b0;
    d.t1_ld = 1'b0;
    d.t2_ld = 1'b0;
    // Three-stage pin sampler; level changes only when two stages agree
    d.pin_sync = {q.pin_sync[1:0], ext_int_pin};
    if (q.pin_sync[2] == q.pin_sync[1])
    begin
      d.pin_lvl = q.pin_sync[2];
    end
    case (q.st)
      itx_pkg::ST_RUN:
      begin
        if (exec)
        begin
          case (instr_op)
            itx_pkg::OP_IRQ_OFF: d.gie = 1'b0;
            itx_pkg::OP_IRQ_ON: d.gie = 1'b1;
            itx_pkg::OP_SKIP_EXT0:
            begin
              if (!q.ic1[itx_pkg::EXT0_EN_BIT] && flags[itx_pkg::FLG_EXT0])
              begin
                d.st = itx_pkg::ST_SKIP;
                clr[itx_pkg::FLG_EXT0] = 1'b1;
              end
            end
            itx_pkg::OP_SKIP_PIN:
            begin
              // Skip when synced level equals the selected test level
              if (q.pin_lvl == q.ic3[itx_pkg::PIN_LVL_BIT])
              begin
                d.st = itx_pkg::ST_SKIP;
              end
            end
            itx_pkg::OP_SKIP_T1:
            begin
              if (!q.ic1[itx_pkg::T1_EN_BIT] && flags[itx_pkg::FLG_T1])
              begin
                d.st = itx_pkg::ST_SKIP;
                clr[itx_pkg::FLG_T1] = 1'b1;
              end
            end
            itx_pkg::OP_SKIP_T2:
            begin
              if (!q.ic1[itx_pkg::T2_EN_BIT] && flags[itx_pkg::FLG_T2])
              begin
                d.st = itx_pkg::ST_SKIP;
                clr[itx_pkg::FLG_T2] = 1'b1;
              end
            end
            itx_pkg::OP_RD_ICTL1:
            begin
              d.acc = q.ic1;
              d.acc_we = 1'b1;
            end
            itx_pkg::OP_RD_ICTL2:
            begin
              d.acc = q.ic2;
              d.acc_we = 1'b1;
            end
            itx_pkg::OP_RD_ICTL3:
            begin
              d.acc = q.ic3;
              d.acc_we = 1'b1;
            end
            itx_pkg::OP_WR_ICTL1: d.ic1 = acc_in;
            itx_pkg::OP_WR_ICTL2: d.ic2 = acc_in;
            itx_pkg::OP_WR_ICTL3: d.ic3 = acc_in;
            itx_pkg::OP_RD_TCTL1:
            begin
              d.acc = q.tc1;
              d.acc_we = 1'b1;
            end
            itx_pkg::OP_RD_TCTL2:
            begin
              d.acc = q.tc2;
              d.acc_we = 1'b1;
            end
            itx_pkg::OP_RD_TCTL3:
            begin
              d.acc = q.tc3;
              d.acc_we = 1'b1;
            end
            itx_pkg::OP_WR_TCTL1: d.tc1 = acc_in;
            itx_pkg::OP_WR_TCTL2: d.tc2 = acc_in;
            itx_pkg::OP_WR_TCTL3: d.tc3 = acc_in;
            itx_pkg::OP_RD_TMR1:
            begin
              d.b = first_timer_count[7:4];
              d.acc = first_timer_count[3:0];
              d.b_we = 1'b1;
              d.acc_we = 1'b1;
            end
            itx_pkg::OP_RD_TMR2:
            begin
              d.b = second_timer_count[7:4];
              d.acc = second_timer_count[3:0];
              d.b_we = 1'b1;
              d.acc_we = 1'b1;
            end
            itx_pkg::OP_WR_TMR1:
            begin
              d.rl1 = {b_in, acc_in};
              d.ld_val = {b_in, acc_in};
              d.t1_ld = 1'b1;
            end
            itx_pkg::OP_WR_TMR2:
            begin
              d.rl2 = {b_in, acc_in};
              d.ld_val = {b_in, acc_in};
              d.t2_ld = 1'b1;
            end
            itx_pkg::OP_WR_RLD1: d.rl1 = {b_in, acc_in};
            default: d.st = itx_pkg::ST_RUN;
          endcase
        end
      end
      itx_pkg::ST_SKIP:
      begin
        // The skipped word is dropped with no effect at all
        if (instr_valid)
        begin
          d.st = itx_pkg::ST_RUN;
        end
      end
      default: d.st = itx_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q.st <= itx_pkg::ST_RUN;
      q.gie <= itx_pkg::RST_GIE;
      q.ic1 <= itx_pkg::RST_NIB;
      q.ic2 <= itx_pkg::RST_NIB;
      q.ic3 <= itx_pkg::RST_NIB;
      q.tc1 <= itx_pkg::RST_NIB;
      q.tc2 <= itx_pkg::RST_NIB;
      q.tc3 <= itx_pkg::RST_NIB;
      q.rl1 <= itx_pkg::RST_CNT;
      q.rl2 <= itx_pkg::RST_CNT;
      q.acc <= itx_pkg::RST_NIB;
      q.acc_we <= 1'b0;
      q.b <= itx_pkg::RST_NIB;
      q.b_we <= 1'b0;
      q.t1_ld <= 1'b0;
      q.t2_ld <= 1'b0;
      q.ld_val <= itx_pkg::RST_CNT;
      q.pin_sync <= {3{itx_pkg::RST_PIN}};
      q.pin_lvl <= itx_pkg::RST_PIN;
    end
    else
    begin
      q <= d;
    end
  end

  assign skip_next = q.st[1];
  assign acc_out = q.acc;
  assign acc_we = q.acc_we;
  assign b_out = q.b;
  assign b_we = q.b_we;
  assign irq_global_enable = q.gie;
  assign irq_ctrl_first = q.ic1;
  assign irq_ctrl_second = q.ic2;
  assign irq_ctrl_third = q.ic3;
  assign tmr_ctrl_first = q.tc1;
  assign tmr_ctrl_second = q.tc2;
  assign tmr_ctrl_third = q.tc3;
  assign first_timer_load = q.t1_ld;
  assign second_timer_load = q.t2_ld;
  assign timer_load_value = q.ld_val;
  assign first_timer_reload = q.rl1;
  assign second_timer_reload = q.rl2;
  assign ext0_req_flag = flags[itx_pkg::FLG_EXT0];
  assign first_timer_req_flag = flags[itx_pkg::FLG_T1];
  assign second_timer_req_flag = flags[itx_pkg::FLG_T2];

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  sequence seq_run_op(itx_pkg::itx_op_t op);
    instr_valid && !skip_next && instr_op == op;
  endsequence

  sequence seq_skip_taken;
    skip_next && instr_valid;
  endsequence

  gie_off_a: assert property (seq_run_op(itx_pkg::OP_IRQ_OFF) |=> !irq_global_enable)
    else $error("Interrupt enable not cleared");
  gie_on_a: assert property (seq_run_op(itx_pkg::OP_IRQ_ON) |=> irq_global_enable)
    else $error("Interrupt enable not set");
  ext0_skip_a: assert property (seq_run_op(itx_pkg::OP_SKIP_EXT0) ##0
    (!irq_ctrl_first[0] && ext0_req_flag && !ext0_req_set) |=> skip_next && !ext0_req_flag)
    else $error("Ext0 skip or clear missing");
  ext0_nop_a: assert property (seq_run_op(itx_pkg::OP_SKIP_EXT0) ##0 irq_ctrl_first[0]
    |=> !skip_next && ext0_req_flag == $past(ext0_req_flag || ext0_req_set))
    else $error("Ext0 test not a no-op");
  pin_skip_a: assert property (seq_run_op(itx_pkg::OP_SKIP_PIN)
    |=> skip_next == ($past(q.pin_lvl) == $past(irq_ctrl_third[2])))
    else $error("Pin test skip wrong");
  ictl_read_a: assert property (seq_run_op(itx_pkg::OP_RD_ICTL3)
    |=> acc_we && acc_out == $past(irq_ctrl_third))
    else $error("Control read wrong");
  ictl_write_a: assert property (seq_run_op(itx_pkg::OP_WR_ICTL2)
    |=> irq_ctrl_second == $past(acc_in) && !acc_we && !b_we)
    else $error("Control write wrong");
  tmr1_read_a: assert property (seq_run_op(itx_pkg::OP_RD_TMR1)
    |=> b_we && acc_we && {b_out, acc_out} == $past(first_timer_count))
    else $error("Timer 1 read wrong");
  tmr1_write_a: assert property (seq_run_op(itx_pkg::OP_WR_TMR1) |=> first_timer_load
    && timer_load_value == first_timer_reload && first_timer_reload == $past({b_in, acc_in}))
    else $error("Timer 1 write wrong");
  rld_only_a: assert property (seq_run_op(itx_pkg::OP_WR_RLD1)
    |=> !first_timer_load && first_timer_reload == $past({b_in, acc_in}))
    else $error("Reload-only write wrong");
  t2_nop_a: assert property (seq_run_op(itx_pkg::OP_SKIP_T2) ##0 irq_ctrl_first[3]
    |=> !skip_next)
    else $error("Timer 2 test not a no-op");
  t1_skip_a: assert property (seq_run_op(itx_pkg::OP_SKIP_T1) ##0
    (!irq_ctrl_first[2] && first_timer_req_flag && !first_timer_req_set)
    |=> skip_next && !first_timer_req_flag)
    else $error("Timer 1 skip or clear missing");
  t1_nop_a: assert property (seq_run_op(itx_pkg::OP_SKIP_T1) ##0 irq_ctrl_first[2]
    |=> !skip_next
    && first_timer_req_flag == $past(first_timer_req_flag || first_timer_req_set))
    else $error("Timer 1 test not a no-op");
  t2_skip_a: assert property (seq_run_op(itx_pkg::OP_SKIP_T2) ##0
    (!irq_ctrl_first[3] && second_timer_req_flag && !second_timer_req_set)
    |=> skip_next && !second_timer_req_flag)
    else $error("Timer 2 skip or clear missing");
  tmr2_write_a: assert property (seq_run_op(itx_pkg::OP_WR_TMR2)
    |=> second_timer_load && !first_timer_load && timer_load_value == second_timer_reload
    && second_timer_reload == $past({b_in, acc_in}))
    else $error("Timer 2 write wrong");
  tctl_write_a: assert property (seq_run_op(itx_pkg::OP_WR_TCTL3)
    |=> tmr_ctrl_third == $past(acc_in) && !acc_we)
    else $error("Timer control write wrong");
  skip_drop_a: assert property (seq_skip_taken |=> !skip_next && !acc_we && !first_timer_load
    && $stable(irq_ctrl_first) && $stable(irq_global_enable))
    else $error("Skipped instruction took effect");
endmodule

// ### bench/itx_seq_model.sv
// Purpose: Sequencer side model holding the accumulator and B register
// Assumes: Device write strobes stand one cycle on ref_clk
// Notes: Captures only on strobes, so a missing strobe leaves stale data
`timescale 1ns/1ps
module itx_seq_model
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic acc_we,
  input wire logic [3:0] acc_out,
  input wire logic b_we,
  input wire logic [3:0] b_out,
  output logic [3:0] acc_q,
  output logic [3:0] b_q
);
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_q <= 4'h0;
      b_q <= 4'h0;
    end
    else
    begin
      if (acc_we)
        acc_q <= acc_out;
      if (b_we)
        b_q <= b_out;
    end
  end
endmodule

// ### bench/irq_timer_instr_exec_tb.sv
// Purpose: Self-checking bench of the interrupt and timer instruction executor
// Assumes: One operation per task call, at least one idle cycle between calls
// Notes: Pin changes are given five edges to pass the input sampler
`timescale 1ns/1ps
module irq_timer_instr_exec_tb;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic instr_valid = 1'b0;
  itx_pkg::itx_op_t instr_op = itx_pkg::OP_NOP;
  logic [3:0] acc_in = 4'h0;
  logic [3:0] b_in = 4'h0;
  logic ext_int_pin = 1'b1;
  logic [2:0] req_set = 3'h0;
  logic [7:0] cnt1 = 8'h00;
  logic [7:0] cnt2 = 8'h00;
  logic skip_next, acc_we, b_we, gie, ld1, ld2, f0, f1, f2;
  logic [3:0] acc_out, b_out, ic1, ic2, ic3, tc1, tc2, tc3, acc_q, b_q;
  logic [7:0] ld_val, rl1, rl2;
  logic [2:0] fl;
  logic [23:0] ctl_v;
  int bad_count = 0;
  int check_count = 0;
  itx_pkg::itx_op_t wr_op [6] = '{itx_pkg::OP_WR_ICTL1, itx_pkg::OP_WR_ICTL2,
    itx_pkg::OP_WR_ICTL3, itx_pkg::OP_WR_TCTL1, itx_pkg::OP_WR_TCTL2, itx_pkg::OP_WR_TCTL3};
  itx_pkg::itx_op_t rd_op [6] = '{itx_pkg::OP_RD_ICTL1, itx_pkg::OP_RD_ICTL2,
    itx_pkg::OP_RD_ICTL3, itx_pkg::OP_RD_TCTL1, itx_pkg::OP_RD_TCTL2, itx_pkg::OP_RD_TCTL3};
  itx_pkg::itx_op_t sk_op [3] = '{itx_pkg::OP_SKIP_EXT0, itx_pkg::OP_SKIP_T1,
    itx_pkg::OP_SKIP_T2};
  int en_bit [3] = '{itx_pkg::EXT0_EN_BIT, itx_pkg::T1_EN_BIT, itx_pkg::T2_EN_BIT};

  assign fl = {f2, f1, f0};
  assign ctl_v = {tc3, tc2, tc1, ic3, ic2, ic1};

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  itx_exec dut (.ref_clk(ref_clk), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr_op(instr_op), .acc_in(acc_in), .b_in(b_in), .ext_int_pin(ext_int_pin),
    .ext0_req_set(req_set[0]), .first_timer_req_set(req_set[1]),
    .second_timer_req_set(req_set[2]), .first_timer_count(cnt1),
    .second_timer_count(cnt2), .skip_next(skip_next), .acc_out(acc_out),
    .acc_we(acc_we), .b_out(b_out), .b_we(b_we), .irq_global_enable(gie),
    .irq_ctrl_first(ic1), .irq_ctrl_second(ic2), .irq_ctrl_third(ic3),
    .tmr_ctrl_first(tc1), .tmr_ctrl_second(tc2), .tmr_ctrl_third(tc3),
    .first_timer_load(ld1), .second_timer_load(ld2), .timer_load_value(ld_val),
    .first_timer_reload(rl1), .second_timer_reload(rl2), .ext0_req_flag(f0),
    .first_timer_req_flag(f1), .second_timer_req_flag(f2));

  itx_seq_model seq (.ref_clk(ref_clk), .arst_n(arst_n), .acc_we(acc_we),
    .acc_out(acc_out), .b_we(b_we), .b_out(b_out), .acc_q(acc_q), .b_q(b_q));

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Effects of the operation are settled when this returns
  task automatic exec(input itx_pkg::itx_op_t op, input logic [3:0] a, input logic [3:0] b);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    acc_in <= a;
    b_in <= b;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  // Strobed results land in the model one edge later
  task automatic rd(input itx_pkg::itx_op_t op);
    exec(op, 4'h0, 4'h0);
    @(posedge ref_clk);
    #1;
  endtask

  task automatic pulse(input int i);
    @(posedge ref_clk);
    req_set[i] <= 1'b1;
    @(posedge ref_clk);
    req_set <= 3'h0;
    #1;
  endtask

  // Enable is low here, so a swallowed enable-on must leave it low
  task automatic swallow();
    exec(itx_pkg::OP_IRQ_ON, 4'h0, 4'h0);
    chk("swallowed gie", 8'h00, {7'h0, gie});
    chk("skip cleared", 8'h00, {7'h0, skip_next});
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #100000;
    bad_count++;
    end_of_test();
  end

  initial
  begin
    logic [3:0] v;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1;
    chk("reset ictl", 8'h00, ctl_v[7:0]);
    chk("reset ictl3 tctl1", 8'h00, ctl_v[15:8]);
    chk("reset tctl", 8'h00, ctl_v[23:16]);
    chk("reset gie", 8'h00, {7'h0, gie});
    exec(itx_pkg::OP_IRQ_ON, 4'h0, 4'h0);
    chk("gie on", 8'h01, {7'h0, gie});
    exec(itx_pkg::OP_IRQ_OFF, 4'h0, 4'h0);
    chk("gie off", 8'h00, {7'h0, gie});
    for (int i = 0; i < 6; i++)
    begin
      v = 4'(i * 5 + 3);
      exec(wr_op[i], v, 4'h0);
      chk("ctl write", {4'h0, v}, {4'h0, ctl_v[i*4+:4]});
    end
    for (int i = 0; i < 6; i++)
    begin
      rd(rd_op[i]);
      chk("ctl read", {4'h0, 4'(i * 5 + 3)}, {4'h0, acc_q});
    end
    exec(itx_pkg::OP_WR_TMR1, 4'ha, 4'h5);
    chk("t1 load", 8'h01, {7'h0, ld1});
    chk("t1 value", 8'h5a, ld_val);
    chk("t1 reload", 8'h5a, rl1);
    exec(itx_pkg::OP_WR_TMR2, 4'hc, 4'h3);
    chk("t2 load", 8'h01, {7'h0, ld2});
    chk("t2 value", 8'h3c, ld_val);
    chk("t2 reload", 8'h3c, rl2);
    exec(itx_pkg::OP_WR_RLD1, 4'h3, 4'hc);
    chk("rld only load", 8'h00, {7'h0, ld1});
    chk("rld only", 8'hc3, rl1);
    @(posedge ref_clk);
    cnt1 <= 8'h96;
    cnt2 <= 8'h3e;
    rd(itx_pkg::OP_RD_TMR1);
    chk("t1 read", 8'h96, {b_q, acc_q});
    rd(itx_pkg::OP_RD_TMR2);
    chk("t2 read", 8'h3e, {b_q, acc_q});
    for (int i = 0; i < 3; i++)
    begin
      exec(itx_pkg::OP_WR_ICTL1, 4'h0, 4'h0);
      exec(sk_op[i], 4'h0, 4'h0);
      chk("no flag no skip", 8'h00, {7'h0, skip_next});
      pulse(i);
      chk("flag set", 8'h01, {7'h0, fl[i]});
      exec(sk_op[i], 4'h0, 4'h0);
      chk("flag skip", 8'h01, {7'h0, skip_next});
      chk("flag cleared", 8'h00, {7'h0, fl[i]});
      swallow();
      exec(itx_pkg::OP_WR_ICTL1, 4'(1 << en_bit[i]), 4'h0);
      pulse(i);
      exec(sk_op[i], 4'h0, 4'h0);
      chk("enabled no skip", 8'h00, {7'h0, skip_next});
      chk("enabled flag kept", 8'h01, {7'h0, fl[i]});
    end
    for (int i = 0; i < 4; i++)
    begin
      exec(itx_pkg::OP_WR_ICTL3, 4'((i >> 1) << itx_pkg::PIN_LVL_BIT), 4'h0);
      @(posedge ref_clk);
      ext_int_pin <= i[0];
      repeat (5) @(posedge ref_clk);
      exec(itx_pkg::OP_SKIP_PIN, 4'h0, 4'h0);
      chk("pin skip", {7'h0, i[0] == i[1]}, {7'h0, skip_next});
      if (skip_next === 1'b1)
        swallow();
    end
    end_of_test();
  end
endmodule
